// ---- core/phase_shedding_config_regs.sv ----
`timescale 1ns/10ps
module phase_shedding_config_regs
   import shed_cfg_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h20
) (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // serial bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // device status pins
   input  wire logic        power_state_input_i,
   input  wire logic        power_good_flag_i,
   // shedding levels from the threshold bank
   input  wire logic [7:0]  shed_level_three_i,
   input  wire logic [7:0]  shed_level_four_i,
   // margins and thresholds, 12.5 mV units
   output logic [2:0]       level_three_margin_o,
   output logic [2:0]       level_four_margin_o,
   output logic [8:0]       level_three_upper_o,
   output logic [7:0]       level_three_lower_o,
   output logic [8:0]       level_four_upper_o,
   output logic [7:0]       level_four_lower_o,
   // phase codes and active phase counts
   output logic [2:0]       current_step_four_o,
   output logic [2:0]       current_step_three_o,
   output logic [2:0]       current_step_two_o,
   output logic [2:0]       current_step_one_o,
   output logic [2:0]       current_step_zero_o,
   output logic [3:0]       step_four_phases_o,
   output logic [3:0]       step_zero_phases_o,
   // output dc offset and frequency
   output logic             dc_offset_en_o,
   output logic             dc_offset_source_o,
   output logic [3:0]       dc_offset_ua_o,
   output logic [4:0]       freq_code_o,
   output logic [10:0]      freq_khz_o
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_DONE, ST_ACK_A, ST_REG, ST_REG_DONE,
      ST_ACK_W, ST_WR, ST_WR_DONE, ST_RD, ST_RD_ACK, ST_RD_NEXT
   } bus_state_t;

   function automatic logic [3:0] phases(input logic [2:0] code);
      phases = {1'b0, code} + 4'h1;
   endfunction
   function automatic logic [10:0] freq_khz(input logic [4:0] code);
      logic [10:0] f;
      f = FREQ_BASE_KHZ + 11'(FREQ_STEP_KHZ * 11'(code));
      freq_khz = (f > FREQ_MAX_KHZ) ? FREQ_MAX_KHZ : f;
   endfunction
   function automatic logic [7:0] lower_thr(input logic [7:0] lvl, input logic [2:0] m);
      lower_thr = (lvl > {5'h00, m}) ? 8'(lvl - {5'h00, m}) : 8'h00;
   endfunction

   logic scl_s, sda_s, psi_s, power_good_flag_s;
   pin_sync #(.RST_VAL(1'b1)) u_scl (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .pin_i(scl_i), .level_o(scl_s));
   pin_sync #(.RST_VAL(1'b1)) u_sda (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .pin_i(sda_i), .level_o(sda_s));
   pin_sync #(.RST_VAL(1'b0)) u_psi (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .pin_i(power_state_input_i), .level_o(psi_s));
   pin_sync #(.RST_VAL(1'b0)) u_pg (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .pin_i(power_good_flag_i), .level_o(power_good_flag_s));

   // ---------------- serial bus slave ----------------
   bus_state_t st_q, st_d;
   logic [2:0] bits_q, bits_d;
   logic [7:0] shift_q, shift_d, ptr_q, ptr_d, rd_byte;
   logic       scl_p_q, sda_p_q, oe_d, wr_en;
   logic       scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;
   always_comb begin
      st_d    = st_q;
      bits_d  = bits_q;
      shift_d = shift_q;
      ptr_d   = ptr_q;
      oe_d    = sda_oe_o;
      wr_en   = 1'b0;
      if (start_c) begin
         st_d   = ST_ADDR;
         bits_d = 3'h0;
         oe_d   = 1'b0;
      end else if (stop_c) begin
         st_d = ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            ST_ADDR, ST_REG, ST_WR: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_s};
                  bits_d  = bits_q + 3'h1;
                  if (bits_q == 3'h7) begin
                     st_d = (st_q == ST_ADDR) ? ST_ADDR_DONE :
                            (st_q == ST_REG) ? ST_REG_DONE : ST_WR_DONE;
                  end
               end
            end
            ST_ADDR_DONE: begin
               if (scl_fall) begin
                  // a silent ninth bit is the not-acknowledge
                  oe_d = (shift_q[7:1] == DEV_ADDR) && power_good_flag_s;
                  st_d = oe_d ? ST_ACK_A : ST_IDLE;
               end
            end
            ST_ACK_A: begin
               if (scl_fall) begin
                  bits_d  = 3'h0;
                  shift_d = shift_q[0] ? rd_byte : shift_q;
                  oe_d    = shift_q[0] && !rd_byte[7];
                  st_d    = shift_q[0] ? ST_RD : ST_REG;
               end
            end
            ST_REG_DONE: begin
               if (scl_fall) begin
                  ptr_d = shift_q;
                  oe_d  = 1'b1;
                  st_d  = ST_ACK_W;
               end
            end
            ST_WR_DONE: begin
               if (scl_fall) begin
                  wr_en = 1'b1;
                  ptr_d = ptr_q + 8'h01;
                  oe_d  = 1'b1;
                  st_d  = ST_ACK_W;
               end
            end
            ST_ACK_W: begin
               if (scl_fall) begin
                  oe_d   = 1'b0;
                  bits_d = 3'h0;
                  st_d   = ST_WR;
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  bits_d  = bits_q + 3'h1;
                  shift_d = {shift_q[6:0], 1'b0};
                  oe_d    = (bits_q != 3'h7) && !shift_q[6];
                  st_d    = (bits_q == 3'h7) ? ST_RD_ACK : ST_RD;
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  st_d  = sda_s ? ST_IDLE : ST_RD_NEXT;
                  ptr_d = sda_s ? ptr_q : ptr_q + 8'h01;
               end
            end
            ST_RD_NEXT: begin
               if (scl_fall) begin
                  shift_d = rd_byte;
                  oe_d    = ~rd_byte[7];
                  bits_d  = 3'h0;
                  st_d    = ST_RD;
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q     <= ST_IDLE;
         bits_q   <= 3'h0;
         shift_q  <= 8'h00;
         ptr_q    <= 8'h00;
         sda_oe_o <= 1'b0;
         sda_o    <= 1'b0;
         scl_p_q  <= 1'b1;
         sda_p_q  <= 1'b1;
      end else begin
         st_q     <= st_d;
         bits_q   <= bits_d;
         shift_q  <= shift_d;
         ptr_q    <= ptr_d;
         sda_oe_o <= oe_d;
         sda_o    <= 1'b0;
         scl_p_q  <= scl_s;
         sda_p_q  <= sda_s;
      end
   end

   // ---------------- register bank ----------------
   logic [7:0] lock_q, lock_d;
   logic       ovr_q, ovr_d;
   logic [2:0] hys3_d, hys4_d, s4_d, s3_d, s2_d, s1_d, s0_d;
   logic [5:0] dc_q, dc_d;
   logic [4:0] freq_d;
   logic       lock_on, shed_ok;

   assign lock_on = (lock_q == LOCK_KEY);
   assign shed_ok = ~lock_on & (psi_s | ovr_q);
   assign dc_offset_en_o     = dc_q[DC_EN_BIT];
   assign dc_offset_source_o = dc_q[DC_POL_BIT];
   assign dc_offset_ua_o     = dc_q[3:0];
   always_comb begin
      case (ptr_q)
         OFS_LOCK:     rd_byte = lock_q;
         OFS_HYS3:     rd_byte = {5'h00, level_three_margin_o};
         OFS_HYS4:     rd_byte = {5'h00, level_four_margin_o};
         OFS_STEP4:    rd_byte = {5'h00, current_step_four_o};
         OFS_STEP3:    rd_byte = {5'h00, current_step_three_o};
         OFS_STEP2:    rd_byte = {5'h00, current_step_two_o};
         OFS_STEP1:    rd_byte = {5'h00, current_step_one_o};
         OFS_STEP0:    rd_byte = {5'h00, current_step_zero_o};
         OFS_DC_OFS:   rd_byte = {2'h0, dc_q};
         OFS_FREQ:     rd_byte = {3'h0, freq_code_o};
         OFS_OVERRIDE: rd_byte = 8'(ovr_q) << OVR_BIT;
         default:      rd_byte = 8'h00;
      endcase
   end

   // refused writes simply fall through with the old value held
   always_comb begin
      lock_d = lock_q;
      ovr_d  = ovr_q;
      hys3_d = level_three_margin_o;
      hys4_d = level_four_margin_o;
      s4_d   = current_step_four_o;
      s3_d   = current_step_three_o;
      s2_d   = current_step_two_o;
      s1_d   = current_step_one_o;
      s0_d   = current_step_zero_o;
      dc_d   = dc_q;
      freq_d = freq_code_o;
      if (wr_en) begin
         case (ptr_q)
            OFS_LOCK:     lock_d = shift_q;
            OFS_HYS3:     if (shed_ok) hys3_d = shift_q[2:0];
            OFS_HYS4:     if (shed_ok) hys4_d = shift_q[2:0];
            OFS_STEP4:    if (shed_ok) s4_d = shift_q[2:0];
            OFS_STEP3:    if (shed_ok) s3_d = shift_q[2:0];
            OFS_STEP2:    if (shed_ok) s2_d = shift_q[2:0];
            OFS_STEP1:    if (shed_ok) s1_d = shift_q[2:0];
            OFS_STEP0:    if (!lock_on) s0_d = shift_q[2:0];
            OFS_DC_OFS:   if (!lock_on) dc_d = shift_q[5:0];
            OFS_FREQ:     if (!lock_on) freq_d = shift_q[4:0];
            OFS_OVERRIDE: if (!lock_on) ovr_d = shift_q[OVR_BIT];
            default:      lock_d = lock_q;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_q               <= RST_LOCK;
         ovr_q                <= 1'b0;
         level_three_margin_o <= RST_HYS;
         level_four_margin_o  <= RST_HYS;
         current_step_four_o  <= RST_STEP4;
         current_step_three_o <= RST_STEP3;
         current_step_two_o   <= RST_STEP2;
         current_step_one_o   <= RST_STEP1;
         current_step_zero_o  <= RST_STEP0;
         dc_q                 <= RST_DC;
         freq_code_o          <= RST_FREQ;
         step_four_phases_o   <= phases(RST_STEP4);
         step_zero_phases_o   <= phases(RST_STEP0);
         freq_khz_o           <= freq_khz(RST_FREQ);
         level_three_upper_o  <= 9'h000;
         level_three_lower_o  <= 8'h00;
         level_four_upper_o   <= 9'h000;
         level_four_lower_o   <= 8'h00;
      end else begin
         lock_q               <= lock_d;
         ovr_q                <= ovr_d;
         level_three_margin_o <= hys3_d;
         level_four_margin_o  <= hys4_d;
         current_step_four_o  <= s4_d;
         current_step_three_o <= s3_d;
         current_step_two_o   <= s2_d;
         current_step_one_o   <= s1_d;
         current_step_zero_o  <= s0_d;
         dc_q                 <= dc_d;
         freq_code_o          <= freq_d;
         step_four_phases_o   <= phases(s4_d);
         step_zero_phases_o   <= phases(s0_d);
         freq_khz_o           <= freq_khz(freq_d);
         level_three_upper_o  <= {1'b0, shed_level_three_i} + {6'h00, hys3_d};
         level_three_lower_o  <= lower_thr(shed_level_three_i, hys3_d);
         level_four_upper_o   <= {1'b0, shed_level_four_i} + {6'h00, hys4_d};
         level_four_lower_o   <= lower_thr(shed_level_four_i, hys4_d);
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_write(logic [7:0] a);
      wr_en && ptr_q == a;
   endsequence
   a_shed_gate: assert property (s_write(OFS_HYS3) ##0 !shed_ok
      |=> $stable(level_three_margin_o)) else $error("gated margin write stored");
   a_step_gate: assert property (s_write(OFS_STEP2) ##0 (lock_on || (!psi_s && !ovr_q))
      |=> $stable(current_step_two_o)) else $error("gated step write stored");
   a_step0_free: assert property (s_write(OFS_STEP0) ##0 !lock_on
      |=> current_step_zero_o == 3'($past(shift_q))) else $error("step zero write lost");
   a_freq_write: assert property (s_write(OFS_FREQ) ##0 !lock_on
      |=> freq_code_o == 5'($past(shift_q))) else $error("freq not applied");
   a_lock_hold: assert property (lock_on && wr_en && ptr_q != OFS_LOCK
      |=> $stable(dc_q) && $stable(current_step_four_o)) else $error("locked map changed");
   a_nak_power_good_flag: assert property (st_q == ST_ADDR_DONE && scl_fall && !power_good_flag_s
      |=> !sda_oe_o [*2]) else $error("acknowledged with power-good low");
   a_phase_plus: assert property ($changed(current_step_four_o)
      |-> step_four_phases_o == {1'b0, current_step_four_o} + 4'h1) else $error("phase count");
   a_freq_400: assert property (freq_code_o == 5'h03 && $stable(freq_code_o)
      |-> freq_khz_o == 11'h190) else $error("code 3 not 400 kHz");
   // thresholds still show their reset value at the first edge after release
   a_margin_upper: assert property ($stable(level_three_margin_o) && !$past(rst_i)
      |-> level_three_upper_o == {1'b0, $past(shed_level_three_i)} + {6'h00, level_three_margin_o})
      else $error("upper threshold wrong");
endmodule // phase_shedding_config_regs

// ---- core/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // pin in, clean level out
   input  wire logic pin_i,
   output logic      level_o
);
   logic [2:0] ff_q;
   logic [2:0] ff_d;
   logic       level_d;

   // level moves only once stages two and three agree
   always_comb begin
      ff_d    = {ff_q[1:0], pin_i};
      level_d = (ff_q[2] == ff_q[1]) ? ff_q[2] : level_o;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ff_q    <= {3{RST_VAL}};
         level_o <= RST_VAL;
      end else begin
         ff_q    <= ff_d;
         level_o <= level_d;
      end
   end
endmodule // pin_sync

// ---- core/shed_cfg_pkg.sv ----
package shed_cfg_pkg;
   // register map (byte offsets on the serial bus)
   localparam logic [7:0] OFS_LOCK     = 8'h00;
   localparam logic [7:0] OFS_HYS3     = 8'h07;
   localparam logic [7:0] OFS_HYS4     = 8'h08;
   localparam logic [7:0] OFS_STEP4    = 8'h09;
   localparam logic [7:0] OFS_STEP3    = 8'h0a;
   localparam logic [7:0] OFS_STEP2    = 8'h0b;
   localparam logic [7:0] OFS_STEP1    = 8'h0c;
   localparam logic [7:0] OFS_STEP0    = 8'h0d;
   localparam logic [7:0] OFS_DC_OFS   = 8'h0e;
   localparam logic [7:0] OFS_FREQ     = 8'h0f;
   localparam logic [7:0] OFS_OVERRIDE = 8'h2d;
   // field positions
   localparam int OVR_BIT    = 2;
   localparam int DC_EN_BIT  = 5;
   localparam int DC_POL_BIT = 4;
   // reset values
   localparam logic [7:0] RST_LOCK  = 8'h00;
   localparam logic [2:0] RST_HYS   = 3'h4;
   localparam logic [2:0] RST_STEP4 = 3'h7;
   localparam logic [2:0] RST_STEP3 = 3'h5;
   localparam logic [2:0] RST_STEP2 = 3'h3;
   localparam logic [2:0] RST_STEP1 = 3'h1;
   localparam logic [2:0] RST_STEP0 = 3'h0;
   localparam logic [5:0] RST_DC    = 6'h00;
   localparam logic [4:0] RST_FREQ  = 5'h00;
   // lock key: this byte in the lock register freezes every register except the lock register itself
   localparam logic [7:0] LOCK_KEY = 8'ha6;
   // one margin code step, in microvolts
   localparam int MARGIN_STEP_UV = 12500;
   // switching frequency table, in kHz
   localparam logic [10:0] FREQ_BASE_KHZ = 11'h0fa;
   localparam logic [10:0] FREQ_STEP_KHZ = 11'h032;
   localparam logic [10:0] FREQ_MAX_KHZ  = 11'h4b0;
endpackage

// ---- sim/phase_shedding_config_regs_test.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end

module phase_shedding_config_regs_test;
   import shed_cfg_pkg::*;

   localparam logic [7:0] RMAP [9] = '{OFS_HYS3, OFS_HYS4, OFS_STEP4, OFS_STEP3, OFS_STEP2,
                                       OFS_STEP1, OFS_STEP0, OFS_DC_OFS, OFS_FREQ};
   localparam logic [7:0] RVAL [9] = '{8'h04, 8'h04, 8'h07, 8'h05, 8'h03, 8'h01, 8'h00,
                                       8'h00, 8'h00};
   localparam logic [4:0] FCODES [6] = '{5'h03, 5'h04, 5'h05, 5'h13, 5'h1f, 5'h00};
   // codes past the 1200 kHz entry saturate there
   localparam logic [10:0] FKHZ [6] = '{11'h190, 11'h1c2, 11'h1f4, 11'h4b0, 11'h4b0, 11'h0fa};

   logic        ref_clk, rst, power_state_input, power_good_flag, scl, host_low, dev_sda, dev_oe, ack, dc_en, dc_src;
   logic [7:0]  lvl3, lvl4, lo3, lo4;
   logic [8:0]  up3, up4;
   logic [2:0]  marg3, marg4, st4, st3, st2, st1, st0;
   logic [3:0]  ph4, ph0, dc_ua, c;
   logic [4:0]  fcode;
   logic [10:0] fkhz;
   int          bad_count, tests_run;
   wire         sda_line;

   // pulled up: low whenever either side pulls
   assign sda_line = ~(host_low | (dev_oe & ~dev_sda));

   phase_shedding_config_regs #(.DEV_ADDR(7'h20)) phase_shedding_config_regs_inst (
      .ref_clk_i(ref_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line),
      .sda_o(dev_sda), .sda_oe_o(dev_oe),
      .power_state_input_i(power_state_input), .power_good_flag_i(power_good_flag),
      .shed_level_three_i(lvl3), .shed_level_four_i(lvl4),
      .level_three_margin_o(marg3), .level_four_margin_o(marg4),
      .level_three_upper_o(up3), .level_three_lower_o(lo3),
      .level_four_upper_o(up4), .level_four_lower_o(lo4),
      .current_step_four_o(st4), .current_step_three_o(st3), .current_step_two_o(st2),
      .current_step_one_o(st1), .current_step_zero_o(st0),
      .step_four_phases_o(ph4), .step_zero_phases_o(ph0),
      .dc_offset_en_o(dc_en), .dc_offset_source_o(dc_src), .dc_offset_ua_o(dc_ua),
      .freq_code_o(fcode), .freq_khz_o(fkhz)
   );

   serial_host_model #(.HALF_CYC(10), .TARGET_ADDR(7'h20)) serial_host_model_inst (
      .ref_clk_i(ref_clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low)
   );

   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic a;
      serial_host_model_inst.write_reg(ofs, d, a);
      `CHK(a, 1'b1)
   endtask

   task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
      logic       a;
      logic [7:0] v;
      serial_host_model_inst.read_reg(ofs, v, a);
      `CHK(a, 1'b1)
      `CHK(v, exp)
   endtask

   // synchroniser needs a few edges before the level counts
   task automatic set_psi(input logic v);
      power_state_input = v;
      repeat (8) @(negedge ref_clk);
   endtask

   task automatic end_test(input string name);
      $display("%s done, mismatches so far %0d", name, bad_count);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (95000) @(posedge ref_clk);
      bad_count++;
      final_report();
   end

   initial begin
      rst = 1'b1;
      power_state_input = 1'b0;
      power_good_flag = 1'b1;
      lvl3 = 8'h40;
      lvl4 = 8'h80;
      bad_count = 0;
      tests_run = 0;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      repeat (10) @(negedge ref_clk);
      `CHK({marg3, up3, lo3}, {3'h4, 9'h044, 8'h3c})
      `CHK({marg4, up4, lo4}, {3'h4, 9'h084, 8'h7c})
      `CHK({st4, st3, ph4}, {3'h7, 3'h5, 4'h8})
      `CHK({st2, st1}, {3'h3, 3'h1})
      `CHK({st0, ph0}, {3'h0, 4'h1})
      `CHK({dc_en, dc_src, dc_ua}, 6'h00)
      `CHK({fcode, fkhz}, {5'h00, 11'h0fa})
      for (int i = 0; i < 9; i++) begin
         rd_chk(RMAP[i], RVAL[i]);
      end
      rd_chk(8'h30, 8'h00);
      end_test("reset values");
      wr(OFS_HYS3, 8'h02);
      `CHK(marg3, 3'h4)
      rd_chk(OFS_HYS3, 8'h04);
      wr(OFS_STEP2, 8'h06);
      `CHK(st2, 3'h3)
      wr(OFS_STEP0, 8'h06);
      `CHK({st0, ph0}, {3'h6, 4'h7})
      end_test("gating, power state low");
      wr(OFS_OVERRIDE, 8'h04);
      rd_chk(OFS_OVERRIDE, 8'h04);
      wr(OFS_HYS3, 8'h07);
      lvl3 = 8'hff;
      repeat (2) @(negedge ref_clk);
      `CHK({marg3, up3, lo3}, {3'h7, 9'h106, 8'hf8})
      for (c = 4'h0; c < 4'h8; c++) begin
         wr(OFS_STEP4, {5'h00, c[2:0]});
         `CHK({st4, ph4}, {c[2:0], c + 4'h1})
      end
      wr(OFS_OVERRIDE, 8'h00);
      set_psi(1'b1);
      wr(OFS_HYS4, 8'h01);
      `CHK({marg4, up4, lo4}, {3'h1, 9'h081, 8'h7f})
      wr(OFS_STEP1, 8'h05);
      `CHK(st1, 3'h5)
      set_psi(1'b0);
      wr(OFS_STEP1, 8'h02);
      `CHK(st1, 3'h5)
      end_test("override and power state");
      for (int i = 0; i < 6; i++) begin
         wr(OFS_FREQ, {3'h0, FCODES[i]});
         `CHK({fcode, fkhz}, {FCODES[i], FKHZ[i]})
      end
      wr(OFS_DC_OFS, 8'h3a);
      `CHK({dc_en, dc_src, dc_ua}, 6'h3a)
      wr(OFS_DC_OFS, 8'h25);
      rd_chk(OFS_DC_OFS, 8'h25);
      end_test("frequency and offset");
      wr(OFS_LOCK, 8'ha5);
      wr(OFS_FREQ, 8'h01);
      `CHK(fcode, 5'h01)
      wr(OFS_LOCK, 8'ha6);
      rd_chk(OFS_LOCK, 8'ha6);
      set_psi(1'b1);
      wr(OFS_STEP0, 8'h02);
      wr(OFS_FREQ, 8'h02);
      wr(OFS_HYS4, 8'h05);
      wr(OFS_DC_OFS, 8'h00);
      `CHK({st0, fcode, marg4, dc_en, dc_src, dc_ua}, {3'h6, 5'h01, 3'h1, 6'h25})
      rd_chk(OFS_FREQ, 8'h01);
      wr(OFS_LOCK, 8'h00);
      wr(OFS_FREQ, 8'h02);
      `CHK(fcode, 5'h02)
      end_test("lock");
      power_good_flag = 1'b0;
      repeat (8) @(negedge ref_clk);
      serial_host_model_inst.write_reg(OFS_FREQ, 8'h05, ack);
      `CHK(ack, 1'b0)
      `CHK(fcode, 5'h02)
      end_test("power good low");
      // second reset in mid-run must drop every written value
      rst = 1'b1;
      power_good_flag = 1'b1;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      repeat (10) @(negedge ref_clk);
      `CHK({fcode, fkhz, st0, st1, dc_en}, {5'h00, 11'h0fa, 3'h0, 3'h1, 1'b0})
      rd_chk(OFS_FREQ, 8'h00);
      end_test("second reset");
      final_report();
   end
endmodule // phase_shedding_config_regs_test

// ---- sim/serial_host_model.sv ----
`timescale 1ns/10ps
module serial_host_model #(
   parameter int         HALF_CYC    = 10,
   parameter logic [6:0] TARGET_ADDR = 7'h20
) (
   // clock
   input  wire logic ref_clk_i,
   // resolved data line
   input  wire logic sda_i,
   // clock drive and data pull-down
   output logic      scl_o,
   output logic      sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   // data moves one cycle after scl falls so the two never land together
   task automatic put_bit(input logic b);
      tick(1);
      sda_low_o = ~b;
      tick(HALF_CYC - 1);
      scl_o = 1'b1;
      tick(HALF_CYC);
      scl_o = 1'b0;
   endtask

   // sampled mid-high, past the device's synchroniser delay
   task automatic get_bit(output logic b);
      tick(1);
      sda_low_o = 1'b0;
      tick(HALF_CYC - 1);
      scl_o = 1'b1;
      tick(HALF_CYC / 2);
      b = sda_i;
      tick(HALF_CYC - HALF_CYC / 2);
      scl_o = 1'b0;
   endtask

   task automatic start_cond();
      tick(1);
      sda_low_o = 1'b0;
      tick(HALF_CYC - 1);
      scl_o = 1'b1;
      tick(HALF_CYC);
      sda_low_o = 1'b1;
      tick(HALF_CYC);
      scl_o = 1'b0;
   endtask

   task automatic stop_cond();
      tick(1);
      sda_low_o = 1'b1;
      tick(HALF_CYC - 1);
      scl_o = 1'b1;
      tick(HALF_CYC);
      sda_low_o = 1'b0;
      tick(HALF_CYC);
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack = ~b;
   endtask

   // single-byte reads only: always ends with a not-acknowledge
   task automatic recv_byte(output logic [7:0] d);
      logic b;
      for (int i = 0; i < 8; i++) begin
         get_bit(b);
         d = {d[6:0], b};
      end
      put_bit(1'b1);
   endtask

   task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ack);
      logic a0, a1, a2;
      start_cond();
      send_byte({TARGET_ADDR, 1'b0}, a0);
      send_byte(ofs, a1);
      send_byte(d, a2);
      stop_cond();
      ack = a0 & a1 & a2;
   endtask

   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ack);
      logic a0, a1, a2;
      start_cond();
      send_byte({TARGET_ADDR, 1'b0}, a0);
      send_byte(ofs, a1);
      start_cond();
      send_byte({TARGET_ADDR, 1'b1}, a2);
      recv_byte(d);
      stop_cond();
      ack = a0 & a1 & a2;
   endtask
endmodule // serial_host_model
